// file: common/lol_pad_pkg.sv
// Constants shared by the loss-of-lock counter and input pad configuration
package lol_pad_pkg;

	// ----------------------------------------------------------------
	// Loss-of-lock counter register
	// ----------------------------------------------------------------
	localparam int        CNT_REG_W   = 8;
	localparam int        CNT_W       = 4;
	localparam logic [3:0] CNT_MAX    = 4'hf;
	localparam logic [3:0] CNT_ZERO   = 4'h0;
	localparam logic [3:0] CNT_RESET  = 4'h0;
	localparam logic [3:0] CNT_ONE    = 4'h1;
	localparam logic [3:0] CNT_RSVD   = 4'h0;

	// ----------------------------------------------------------------
	// Reference input pad configuration register
	// ----------------------------------------------------------------
	localparam int         PAD_REG_W  = 16;
	localparam int         PAD_RW_W   = 10;
	localparam logic [5:0] PAD_RSVD   = 6'h00;
	localparam int         BIT_LVDS   = 9;
	localparam int         BIT_HCSL   = 8;
	localparam int         BIT_LDO    = 7;
	localparam int         BIT_SBIAS  = 6;
	localparam int         BIT_SPARE_HI = 5;
	localparam int         BIT_SPARE_LO = 4;
	localparam int         BIT_DCBIAS = 3;
	localparam int         BIT_PAD_EN = 2;
	localparam int         BIT_CMOS   = 1;
	localparam int         BIT_NMOS   = 0;
	localparam logic [9:0] PAD_RESET  = 10'h080;

	// ----------------------------------------------------------------
	// Lock status synchroniser
	// ----------------------------------------------------------------
	localparam int         SYNC_STAGES = 2;
	localparam logic       LOCK_RESET  = 1'b0;

endpackage : lol_pad_pkg

// file: verilog/level_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none

module level_sync (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic async_in,
	output logic      sync_out
);
	import lol_pad_pkg::*;

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_q <= LOCK_RESET;
			sync_q <= LOCK_RESET;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : level_sync

`default_nettype wire

// file: verilog/lol_counter_and_refclk_pad_cfg.sv
// Loss-of-lock event counter and reference input pad configuration
// Notes on behaviour
// - Each locked-to-unlocked drop of lock status adds one to count.
// - The count stops at fifteen and never wraps back to zero.
// - Zero written clears the count; other values preset, then count on.
// - Lock status is live: zero while unlocked, one while locked.
// - Bit 9 turns on LVDS-style input termination; resets to zero.
// - Bit 8 turns on HCSL-style input termination; resets to zero.
// - Bit 7 turns on the input buffer regulator; resets to one.
// - Bit 6 enables single-ended self-bias; set it for AC coupling.
// - Bits 5 and 4 are plain storage with no effect, reset zero.
// - Bit 3 turns on differential DC bias; software sets it for AC coupling.
// - Bit 2 enables the input pad; needed in clock generator mode.
// - Bit 1 picks input type: zero differential, one single-ended CMOS.
// - Bit 0 picks input pair: zero PMOS low common mode, one NMOS.
`timescale 1ns/10ps
`default_nettype none

module lol_counter_and_refclk_pad_cfg (
	input  wire logic                              sys_clk,
	input  wire logic                              srst,
	input  wire logic                              lock_status_raw,
	input  wire logic                              cnt_wr_en,
	input  wire logic [lol_pad_pkg::CNT_REG_W-1:0] cnt_wr_data,
	output logic      [lol_pad_pkg::CNT_REG_W-1:0] cnt_rd_data,
	input  wire logic                              pad_wr_en,
	input  wire logic [lol_pad_pkg::PAD_REG_W-1:0] pad_wr_data,
	output logic      [lol_pad_pkg::PAD_REG_W-1:0] pad_rd_data,
	output logic                                   lock_status,
	output logic                                   lvds_termination_enable,
	output logic                                   hcsl_termination_enable,
	output logic                                   input_regulator_enable,
	output logic                                   self_bias_enable,
	output logic                                   differential_dc_bias_enable,
	output logic                                   input_pad_enable,
	output logic                                   single_ended_select,
	output logic                                   nmos_pair_select
);
	import lol_pad_pkg::*;

	// ----------------------------------------------------------------
	// Lock status capture
	// ----------------------------------------------------------------
	logic lock_sync;
	logic lock_prev_q;
	logic lock_prev_d;
	logic lock_fall;

	// The lock detector runs off analog timing, so it is synchronised
	level_sync i_level_sync (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in (lock_status_raw),
		.sync_out (lock_sync)
	);

	always_comb begin
		lock_prev_d = lock_sync;
		lock_fall   = lock_prev_q & ~lock_sync;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			lock_prev_q <= LOCK_RESET;
		end else begin
			lock_prev_q <= lock_prev_d;
		end
	end

	assign lock_status = lock_sync;

	// ----------------------------------------------------------------
	// Loss-of-lock counter
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] cnt_base;

	// A drop seen in the same cycle as a write is added on top of the
	// written value, so a drop meeting a write is lost only when fifteen is written.
	always_comb begin
		cnt_base = cnt_wr_en ? cnt_wr_data[CNT_W-1:0] : cnt_q;
		cnt_d    = cnt_base;
		if (lock_fall && (cnt_base != CNT_MAX)) begin
			cnt_d = cnt_base + CNT_ONE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_q <= CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign cnt_rd_data = {CNT_RSVD, cnt_q};

	// ----------------------------------------------------------------
	// Reference input pad configuration
	// ----------------------------------------------------------------
	logic [PAD_RW_W-1:0] pad_q;
	logic [PAD_RW_W-1:0] pad_d;

	// Only the ten defined bits are stored; reserved bits have no flops
	always_comb begin
		pad_d = pad_q;
		if (pad_wr_en) begin
			pad_d = pad_wr_data[PAD_RW_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pad_q <= PAD_RESET;
		end else begin
			pad_q <= pad_d;
		end
	end

	assign pad_rd_data = {PAD_RSVD, pad_q};

	assign lvds_termination_enable     = pad_q[BIT_LVDS];
	assign hcsl_termination_enable     = pad_q[BIT_HCSL];
	assign input_regulator_enable      = pad_q[BIT_LDO];
	// Coupling choice is software's job; hardware simply applies the bias
	assign self_bias_enable            = pad_q[BIT_SBIAS];
	assign differential_dc_bias_enable = pad_q[BIT_DCBIAS];
	// Leaving the pad off in synthesizer mode saves power and noise
	assign input_pad_enable            = pad_q[BIT_PAD_EN];
	assign single_ended_select         = pad_q[BIT_CMOS];
	assign nmos_pair_select            = pad_q[BIT_NMOS];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_count_drop;
		(lock_fall && !cnt_wr_en && cnt_q != CNT_MAX)
			|=> (cnt_q == $past(cnt_q) + CNT_ONE);
	endproperty
	a_count_drop: assert property (p_count_drop)
		else $error("counter did not step on loss of lock");

	property p_saturate;
		(cnt_q == CNT_MAX && !cnt_wr_en) |=> (cnt_q == CNT_MAX);
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("counter left its saturated value");

	property p_hold;
		(!lock_fall && !cnt_wr_en) |=> $stable(cnt_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter changed without a cause");

	property p_clear;
		(cnt_wr_en && cnt_wr_data[CNT_W-1:0] == CNT_ZERO && !lock_fall)
			|=> (cnt_q == CNT_ZERO);
	endproperty
	a_clear: assert property (p_clear)
		else $error("write of zero did not clear counter");

	property p_preset_then_count;
		(cnt_wr_en && !lock_fall && cnt_wr_data[CNT_W-1:0] != CNT_MAX)
			##1 (lock_fall && !cnt_wr_en)
			|=> (cnt_q == $past(cnt_wr_data[CNT_W-1:0], 2) + CNT_ONE);
	endproperty
	a_preset_then_count: assert property (p_preset_then_count)
		else $error("counting did not resume from preset");

	// A write racing a drop keeps the drop: the written value is the base
	property p_write_and_drop;
		(cnt_wr_en && lock_fall && cnt_wr_data[CNT_W-1:0] != CNT_MAX)
			|=> (cnt_q == $past(cnt_wr_data[CNT_W-1:0]) + CNT_ONE);
	endproperty
	a_write_and_drop: assert property (p_write_and_drop)
		else $error("drop lost when it met a counter write");

	property p_write_drop_sat;
		(cnt_wr_en && lock_fall && cnt_wr_data[CNT_W-1:0] == CNT_MAX)
			|=> (cnt_q == CNT_MAX);
	endproperty
	a_write_drop_sat: assert property (p_write_drop_sat)
		else $error("preset to maximum wrapped on a drop");

	property p_preset;
		(cnt_wr_en && !lock_fall)
			|=> (cnt_q == $past(cnt_wr_data[CNT_W-1:0]));
	endproperty
	a_preset: assert property (p_preset)
		else $error("counter write did not preset the value");

	property p_cnt_rsvd_write;
		(cnt_wr_en && cnt_wr_data[CNT_REG_W-1:CNT_W] != CNT_RSVD)
			|=> (cnt_rd_data[CNT_REG_W-1:CNT_W] == CNT_RSVD);
	endproperty
	a_cnt_rsvd_write: assert property (p_cnt_rsvd_write)
		else $error("counter reserved bits took a write");

	// Watched at the port, so a detector on the wrong edge shows up too
	property p_drop_seen;
		($past(lock_status) && !lock_status && !$past(srst)
			&& !cnt_wr_en && cnt_q != CNT_MAX)
			|=> (cnt_q == $past(cnt_q) + CNT_ONE);
	endproperty
	a_drop_seen: assert property (p_drop_seen)
		else $error("falling lock status was not counted");

	property p_lock_live;
		!srst [*3] |-> (lock_status == $past(lock_status_raw, 2));
	endproperty
	a_lock_live: assert property (p_lock_live)
		else $error("lock status not following detector");

	property p_term_bits;
		pad_wr_en |=> (lvds_termination_enable == $past(pad_wr_data[BIT_LVDS]))
			&& (hcsl_termination_enable == $past(pad_wr_data[BIT_HCSL]));
	endproperty
	a_term_bits: assert property (p_term_bits)
		else $error("termination enables not written");

	property p_reset_values;
		@(posedge sys_clk) disable iff (1'b0)
		srst |=> (input_regulator_enable && !lvds_termination_enable
			&& !hcsl_termination_enable && !input_pad_enable
			&& cnt_q == CNT_RESET && pad_rd_data[5:4] == 2'h0);
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("wrong value after reset");

	property p_bias_bits;
		pad_wr_en |=> (self_bias_enable == $past(pad_wr_data[BIT_SBIAS]))
			&& (differential_dc_bias_enable
				== $past(pad_wr_data[BIT_DCBIAS]))
			&& (input_regulator_enable == $past(pad_wr_data[BIT_LDO]));
	endproperty
	a_bias_bits: assert property (p_bias_bits)
		else $error("bias enables not written");

	property p_spare_store;
		pad_wr_en |=> (pad_rd_data[BIT_SPARE_HI:BIT_SPARE_LO]
			== $past(pad_wr_data[BIT_SPARE_HI:BIT_SPARE_LO]));
	endproperty
	a_spare_store: assert property (p_spare_store)
		else $error("spare bits did not store");

	property p_pad_select;
		pad_wr_en |=> (input_pad_enable == $past(pad_wr_data[BIT_PAD_EN]))
			&& (single_ended_select == $past(pad_wr_data[BIT_CMOS]))
			&& (nmos_pair_select == $past(pad_wr_data[BIT_NMOS]));
	endproperty
	a_pad_select: assert property (p_pad_select)
		else $error("pad select bits not written");

	property p_pad_hold;
		!pad_wr_en |=> $stable(pad_rd_data);
	endproperty
	a_pad_hold: assert property (p_pad_hold)
		else $error("pad register changed without a write");

	// ----------------------------------------------------------------
	// Read-back and reset checks
	// ----------------------------------------------------------------

	property p_pad_image;
		pad_wr_en |=> (pad_rd_data
			== {PAD_RSVD, $past(pad_wr_data[PAD_RW_W-1:0])});
	endproperty
	a_pad_image: assert property (p_pad_image)
		else $error("pad register read back differs from write");

	property p_pad_rsvd_write;
		(pad_wr_en && pad_wr_data[PAD_REG_W-1:PAD_RW_W] != PAD_RSVD)
			|=> (pad_rd_data[PAD_REG_W-1:PAD_RW_W] == PAD_RSVD);
	endproperty
	a_pad_rsvd_write: assert property (p_pad_rsvd_write)
		else $error("pad reserved bits took a write");

	// Both flops clear, so a lock held through reset still reads unlocked
	property p_lock_reset;
		@(posedge sys_clk) disable iff (1'b0)
		srst |=> !lock_status;
	endproperty
	a_lock_reset: assert property (p_lock_reset)
		else $error("lock status not cleared by reset");

	property p_reserved_zero;
		(cnt_rd_data[7:4] == 4'h0) && (pad_rd_data[15:10] == 6'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");

	c_saturate: cover property (lock_fall && cnt_q == CNT_MAX);
	c_write_and_drop: cover property (lock_fall && cnt_wr_en);
	c_pad_cmos: cover property (pad_wr_en ##1 single_ended_select);
	c_clear: cover property (cnt_q != CNT_ZERO ##1 cnt_q == CNT_ZERO);
	// Preset landing one cycle ahead of a drop
	c_preset_then_count: cover property (cnt_wr_en ##1 lock_fall);

endmodule : lol_counter_and_refclk_pad_cfg

`default_nettype wire

// file: testbench/lol_counter_and_refclk_pad_cfg_bench.sv
// Self-checking bench for the loss-of-lock counter and pad configuration
`timescale 1ns/10ps
`default_nettype none

module lol_counter_and_refclk_pad_cfg_bench;
	import lol_pad_pkg::*;

	logic        sys_clk;
	logic        srst;
	logic        raw;
	logic        cnt_we;
	logic [7:0]  cnt_wd;
	logic [7:0]  cnt_rd;
	logic        pad_we;
	logic [15:0] pad_wd;
	logic [15:0] pad_rd;
	logic        lock;
	wire  [9:0]  outs;
	int          fail_count;
	int          cmp_count;

	lol_counter_and_refclk_pad_cfg i_lol_counter_and_refclk_pad_cfg (
		.sys_clk                     (sys_clk),
		.srst                        (srst),
		.lock_status_raw             (raw),
		.cnt_wr_en                   (cnt_we),
		.cnt_wr_data                 (cnt_wd),
		.cnt_rd_data                 (cnt_rd),
		.pad_wr_en                   (pad_we),
		.pad_wr_data                 (pad_wd),
		.pad_rd_data                 (pad_rd),
		.lock_status                 (lock),
		.lvds_termination_enable     (outs[9]),
		.hcsl_termination_enable     (outs[8]),
		.input_regulator_enable      (outs[7]),
		.self_bias_enable            (outs[6]),
		.differential_dc_bias_enable (outs[3]),
		.input_pad_enable            (outs[2]),
		.single_ended_select         (outs[1]),
		.nmos_pair_select            (outs[0])
	);
	// Bits 5:4 have no output; keep them at zero for the comparison
	assign outs[5:4] = 2'b00;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("errors %0d, comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic do_reset;
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
	endtask : do_reset

	// Write takes effect on the strobe edge; read back 1 ns after that edge
	task automatic wr_cnt(input logic [7:0] v);
		@(posedge sys_clk);
		cnt_we <= 1'b1;
		cnt_wd <= v;
		@(posedge sys_clk);
		cnt_we <= 1'b0;
		#1;
	endtask : wr_cnt

	task automatic wr_pad(input logic [15:0] v);
		@(posedge sys_clk);
		pad_we <= 1'b1;
		pad_wd <= v;
		@(posedge sys_clk);
		pad_we <= 1'b0;
		#1;
	endtask : wr_pad

	// One lock then unlock; the synchroniser needs two edges, the count a third
	task automatic drop(input logic [3:0] exp);
		@(posedge sys_clk);
		raw <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 check({15'h0, lock}, 16'h0001);
		@(posedge sys_clk);
		raw <= 1'b0;
		repeat (5) @(posedge sys_clk);
		#1 check({15'h0, lock}, 16'h0000);
		check({8'h00, cnt_rd}, {12'h000, exp});
	endtask : drop

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic check_reset;
		@(posedge sys_clk);
		#1 check({8'h00, cnt_rd}, 16'h0000);
		check(pad_rd, 16'h0080);
		check({6'h00, outs}, 16'h0080);
		check({15'h0, lock}, 16'h0000);
	endtask : check_reset

	task automatic pad_walk;
		logic [15:0] v;
		for (int i = 0; i < 18; i++) begin
			v = (i < 16) ? (16'h0001 << i) : ((i == 16) ? 16'hffff : 16'h0000);
			wr_pad(v);
			check(pad_rd, v & 16'h03ff);
			check({6'h00, outs}, v & 16'h03cf);
		end
	endtask : pad_walk

	task automatic count_run;
		drop(4'h1);
		wr_cnt(8'hfd);
		check({8'h00, cnt_rd}, 16'h000d);
		drop(4'he);
		drop(4'hf);
		drop(4'hf);
		wr_cnt(8'hf0);
		check({8'h00, cnt_rd}, 16'h0000);
		drop(4'h1);
	endtask : count_run

	// Write lands gap+1 edges after the raw drop: 2 meets the drop, 1 leads it
	task automatic write_with_drop(input logic [7:0] v, input int gap,
		input logic [3:0] exp);
		@(posedge sys_clk);
		raw <= 1'b1;
		repeat (5) @(posedge sys_clk);
		raw <= 1'b0;
		repeat (gap) @(posedge sys_clk);
		cnt_we <= 1'b1;
		cnt_wd <= v;
		@(posedge sys_clk);
		cnt_we <= 1'b0;
		repeat (3 - gap) @(posedge sys_clk);
		#1 check({8'h00, cnt_rd}, {12'h000, exp});
	endtask : write_with_drop

	// Writes landing with, or just before, a lock drop
	task automatic race_run;
		write_with_drop(8'h05, 2, 4'h6);
		write_with_drop(8'h09, 1, 4'ha);
		write_with_drop(8'h0f, 2, 4'hf);
		write_with_drop(8'h00, 2, 4'h1);
	endtask : race_run

	// Reset while locked and configured, then count again from zero
	task automatic reset_run;
		@(posedge sys_clk);
		raw <= 1'b1;
		wr_pad(16'h03ff);
		do_reset();
		check_reset();
		drop(4'h1);
	endtask : reset_run

	// ----------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial begin
		srst       = 1'b1;
		raw        = 1'b0;
		cnt_we     = 1'b0;
		cnt_wd     = 8'h00;
		pad_we     = 1'b0;
		pad_wd     = 16'h0000;
		fail_count = 0;
		cmp_count  = 0;
		do_reset();
		check_reset();
		pad_walk();
		count_run();
		race_run();
		// A second reset in mid-run must restore the defaults
		reset_run();
		print_verdict();
	end

endmodule : lol_counter_and_refclk_pad_cfg_bench

`default_nettype wire
